// [hw/sac_pkg.sv]
//------------------------------------------------------------
//------------------------------------------------------------
package sac_pkg;
    // register indexes; the byte address on the bus is four times the index
    localparam logic [7:0] SAC_IDX_OFFSET_HIGH = 8'h84;
    localparam logic [7:0] SAC_IDX_OFFSET_LOW = 8'h85;
    localparam logic [7:0] SAC_IDX_GAIN_TRIM = 8'h86;
    localparam logic [7:0] SAC_IDX_OVC_CONFIG = 8'h87;
    localparam logic [7:0] SAC_IDX_IRQ_STATUS = 8'h88;
    localparam logic [7:0] SAC_IDX_IRQ_MASK = 8'h89;
    localparam logic [7:0] SAC_IDX_RESULT = 8'h8a;
    localparam logic [7:0] SAC_IDX_STATE = 8'h8b;
    // field positions
    localparam int SAC_OVC_EN_BIT = 15;
    localparam int SAC_OVC_POL_BIT = 14;
    localparam int SAC_OVC_SPARE_BIT = 13;
    localparam int SAC_OVC_CNT_MSB = 12;
    localparam int SAC_OVC_CNT_LSB = 8;
    localparam int SAC_GAIN_FRAC_BITS = 16;
    // interrupt status bits
    localparam int SAC_IRQ_RESULT_BIT = 0;
    localparam int SAC_IRQ_FAULT_BIT = 1;
    localparam int SAC_IRQ_SAT_BIT = 2;
    // reset values
    localparam logic [15:0] SAC_OFFSET_HIGH_RST = 16'h0000;
    localparam logic [7:0] SAC_OFFSET_LOW_RST = 8'h00;
    localparam logic [15:0] SAC_GAIN_TRIM_RST = 16'h0000;
    localparam logic [15:0] SAC_OVC_CONFIG_RST = 16'h0000;
    localparam logic [2:0] SAC_IRQ_RST = 3'h0;
    // corrector pipeline states
    typedef enum logic [1:0] {SAC_IDLE, SAC_ADD, SAC_MUL, SAC_DONE} sac_state_t;
endpackage

// [hw/sac_corrector.sv]
`timescale 1ns/100ps
// two-step correction: offset add, then gain multiply with saturation
module sac_corrector (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request
    input wire logic start,
    input wire logic [23:0] raw_result,
    input wire logic [23:0] offset_trim_value,
    input wire logic [15:0] gain_trim_value,
    // answer
    output logic busy,
    output logic done,
    output logic saturated,
    output logic [23:0] corrected
);
    //------------------------------------------------------------
    // sequencing
    //------------------------------------------------------------
    sac_pkg::sac_state_t state_reg, state_next;
    logic signed [24:0] sum_reg, sum_next;
    logic [23:0] out_reg, out_next;
    logic sat_reg, sat_next;
    logic signed [42:0] product;
    logic signed [26:0] scaled;

    // factor is 1 + code/2^16, so product = sum*2^16 + sum*code
    assign product = (43'(sum_reg) <<< sac_pkg::SAC_GAIN_FRAC_BITS)
                   + 43'(sum_reg) * 43'(signed'(gain_trim_value));
    assign scaled = 27'(product >>> sac_pkg::SAC_GAIN_FRAC_BITS);

    // next state and datapath
    always_comb begin
        state_next = state_reg;
        sum_next = sum_reg;
        out_next = out_reg;
        sat_next = sat_reg;
        case (state_reg)
            sac_pkg::SAC_IDLE: begin
                if (start) begin
                    // capture the raw code now: the converter may move on after its strobe
                    sum_next = 25'(signed'(raw_result));
                    state_next = sac_pkg::SAC_ADD;
                end
            end
            sac_pkg::SAC_ADD: begin
                // raw code add; weight of one step follows the converter scale
                sum_next = sum_reg + 25'(signed'(offset_trim_value));
                state_next = sac_pkg::SAC_MUL;
            end
            sac_pkg::SAC_MUL: begin
                // clamp rather than wrap: a wrapped current reading flips sign
                if (scaled > 27'sh7fffff) begin
                    out_next = 24'h7fffff;
                    sat_next = 1'b1;
                end else if (scaled < -27'sh800000) begin
                    out_next = 24'h800000;
                    sat_next = 1'b1;
                end else begin
                    out_next = scaled[23:0];
                    sat_next = 1'b0;
                end
                state_next = sac_pkg::SAC_DONE;
            end
            sac_pkg::SAC_DONE: begin
                state_next = sac_pkg::SAC_IDLE;
            end
            default: begin
                state_next = sac_pkg::SAC_IDLE;
            end
        endcase
    end

    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= sac_pkg::SAC_IDLE;
            sum_reg <= 25'sh0;
            out_reg <= 24'h0;
            sat_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sum_reg <= sum_next;
            out_reg <= out_next;
            sat_reg <= sat_next;
        end
    end

    assign busy = (state_reg != sac_pkg::SAC_IDLE);
    assign done = (state_reg == sac_pkg::SAC_DONE);
    assign saturated = sat_reg;
    assign corrected = out_reg;
endmodule

// [hw/sac_top.sv]
`timescale 1ns/100ps
// shunt converter A trim and overcurrent comparator configuration
module sac_top (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter side, same clock
    input wire logic shunt_converter_a_enable,
    input wire logic raw_valid,
    input wire logic [23:0] raw_result,
    // threshold flags from the comparator bank, external pins
    input wire logic [3:0] high_threshold_flag,
    input wire logic [3:0] low_threshold_flag,
    // results and status
    output logic result_valid,
    output logic [23:0] result_data,
    output logic fast_filter_enable,
    output logic [4:0] overcurrent_sample_count,
    output logic overcurrent_fault_output,
    output logic irq
);
    //------------------------------------------------------------
    // register state
    //------------------------------------------------------------
    logic [15:0] offset_high_reg, offset_high_next;
    logic [7:0] offset_low_reg, offset_low_next;
    logic [15:0] gain_trim_reg, gain_trim_next;
    logic [15:0] ovc_config_reg, ovc_config_next;
    logic [2:0] irq_status_reg, irq_status_next;
    logic [2:0] irq_mask_reg, irq_mask_next;
    logic [23:0] result_reg, result_next;
    logic result_valid_reg, result_valid_next;
    logic fault_reg, fault_next;
    logic [7:0] flags_meta_reg, flags_sync_reg;
    logic [31:0] prdata_reg, prdata_next;

    logic [23:0] offset_trim_value;
    logic [15:0] gain_trim_value;
    logic ovc_enable, ovc_polarity, ovc_armed, fault_raw;
    logic wr_access, rd_access, addr_ok, addr_hit;
    logic [7:0] reg_index;
    logic corr_busy, corr_done, corr_sat;
    logic [23:0] corr_out;
    logic [2:0] events;

    //------------------------------------------------------------
    // field views
    //------------------------------------------------------------
    // offset trim is split high word plus upper byte of the low word
    assign offset_trim_value = {offset_high_reg, offset_low_reg};
    assign gain_trim_value = gain_trim_reg;
    assign ovc_enable = ovc_config_reg[sac_pkg::SAC_OVC_EN_BIT];
    assign ovc_polarity = ovc_config_reg[sac_pkg::SAC_OVC_POL_BIT];
    // comparator only runs while the converter itself is enabled
    assign ovc_armed = ovc_enable && shunt_converter_a_enable;
    assign fast_filter_enable = ovc_armed;
    assign overcurrent_sample_count = ovc_config_reg[sac_pkg::SAC_OVC_CNT_MSB:sac_pkg::SAC_OVC_CNT_LSB];

    //------------------------------------------------------------
    // apb decode
    //------------------------------------------------------------
    // register byte address is four times the printed index
    assign reg_index = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
    assign addr_hit = addr_ok && (reg_index >= sac_pkg::SAC_IDX_OFFSET_HIGH)
                      && (reg_index <= sac_pkg::SAC_IDX_STATE);
    assign wr_access = psel && penable && pwrite;
    assign rd_access = psel && !penable && !pwrite;
    assign pready = 1'b1; // zero wait states
    assign pslverr = psel && penable && !addr_hit;

    //------------------------------------------------------------
    // threshold flag synchroniser
    //------------------------------------------------------------
    // flags come from outside this clock domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_meta_reg <= 8'h00;
            flags_sync_reg <= 8'h00;
        end else begin
            flags_meta_reg <= {high_threshold_flag, low_threshold_flag};
            flags_sync_reg <= flags_meta_reg;
        end
    end

    // any high or low threshold flag raises the fault while armed
    assign fault_raw = ovc_armed && (|flags_sync_reg);

    //------------------------------------------------------------
    // correction engine
    //------------------------------------------------------------
    sac_corrector u_corrector (
        .pclk(pclk),
        .presetn(presetn),
        .start(raw_valid && !corr_busy && shunt_converter_a_enable),
        .raw_result(raw_result),
        .offset_trim_value(offset_trim_value),
        .gain_trim_value(gain_trim_value),
        .busy(corr_busy),
        .done(corr_done),
        .saturated(corr_sat),
        .corrected(corr_out)
    );

    // events for the sticky status register
    always_comb begin
        events = 3'h0;
        events[sac_pkg::SAC_IRQ_RESULT_BIT] = corr_done;
        events[sac_pkg::SAC_IRQ_FAULT_BIT] = fault_next && !fault_reg;
        events[sac_pkg::SAC_IRQ_SAT_BIT] = corr_done && corr_sat;
    end

    //------------------------------------------------------------
    // register write path and status
    //------------------------------------------------------------
    // one write per access phase; byte lanes honoured for 16-bit words
    always_comb begin
        offset_high_next = offset_high_reg;
        offset_low_next = offset_low_reg;
        gain_trim_next = gain_trim_reg;
        ovc_config_next = ovc_config_reg;
        irq_mask_next = irq_mask_reg;
        irq_status_next = irq_status_reg;
        if (wr_access && addr_ok) begin
            case (reg_index)
                sac_pkg::SAC_IDX_OFFSET_HIGH: begin
                    if (pstrb[0]) offset_high_next[7:0] = pwdata[7:0];
                    if (pstrb[1]) offset_high_next[15:8] = pwdata[15:8];
                end
                sac_pkg::SAC_IDX_OFFSET_LOW: begin
                    // low byte is reserved and keeps no state
                    if (pstrb[1]) offset_low_next = pwdata[15:8];
                end
                sac_pkg::SAC_IDX_GAIN_TRIM: begin
                    if (pstrb[0]) gain_trim_next[7:0] = pwdata[7:0];
                    if (pstrb[1]) gain_trim_next[15:8] = pwdata[15:8];
                end
                sac_pkg::SAC_IDX_OVC_CONFIG: begin
                    // bits 7:0 are never stored
                    if (pstrb[1]) ovc_config_next[15:8] = pwdata[15:8];
                end
                sac_pkg::SAC_IDX_IRQ_MASK: begin
                    if (pstrb[0]) irq_mask_next = pwdata[2:0];
                end
                sac_pkg::SAC_IDX_IRQ_STATUS: begin
                    if (pstrb[0]) irq_status_next = irq_status_reg & ~pwdata[2:0];
                end
                default: begin
                end
            endcase
        end
        // a new event wins over a clear in the same cycle
        irq_status_next = irq_status_next | events;
    end

    // read mux, registered during the setup phase
    always_comb begin
        prdata_next = prdata_reg;
        if (rd_access) begin
            prdata_next = 32'h0;
            if (addr_ok) begin
                case (reg_index)
                    sac_pkg::SAC_IDX_OFFSET_HIGH: prdata_next[15:0] = offset_high_reg;
                    sac_pkg::SAC_IDX_OFFSET_LOW: prdata_next[15:0] = {offset_low_reg, 8'h00};
                    sac_pkg::SAC_IDX_GAIN_TRIM: prdata_next[15:0] = gain_trim_reg;
                    sac_pkg::SAC_IDX_OVC_CONFIG: prdata_next[15:0] = ovc_config_reg;
                    sac_pkg::SAC_IDX_IRQ_STATUS: prdata_next[2:0] = irq_status_reg;
                    sac_pkg::SAC_IDX_IRQ_MASK: prdata_next[2:0] = irq_mask_reg;
                    sac_pkg::SAC_IDX_RESULT: prdata_next[23:0] = result_reg;
                    sac_pkg::SAC_IDX_STATE: prdata_next[3:0] = {corr_busy, ovc_armed, fault_reg, overcurrent_fault_output};
                    default: prdata_next = 32'h0;
                endcase
            end
        end
    end

    // result capture and fault tracking
    always_comb begin
        result_next = result_reg;
        result_valid_next = corr_done;
        fault_next = fault_raw;
        if (corr_done) begin
            result_next = corr_out;
        end
        // a disabled converter clears its data
        if (!shunt_converter_a_enable) begin
            result_next = 24'h0;
        end
    end

    // trim and comparator configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            offset_high_reg <= sac_pkg::SAC_OFFSET_HIGH_RST;
            offset_low_reg <= sac_pkg::SAC_OFFSET_LOW_RST;
            gain_trim_reg <= sac_pkg::SAC_GAIN_TRIM_RST;
            ovc_config_reg <= sac_pkg::SAC_OVC_CONFIG_RST;
        end else begin
            offset_high_reg <= offset_high_next;
            offset_low_reg <= offset_low_next;
            gain_trim_reg <= gain_trim_next;
            ovc_config_reg <= ovc_config_next;
        end
    end

    // sticky status and its mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= sac_pkg::SAC_IRQ_RST;
            irq_mask_reg <= sac_pkg::SAC_IRQ_RST;
        end else begin
            irq_status_reg <= irq_status_next;
            irq_mask_reg <= irq_mask_next;
        end
    end

    // corrected result and fault level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= 24'h0;
            result_valid_reg <= 1'b0;
            fault_reg <= 1'b0;
        end else begin
            result_reg <= result_next;
            result_valid_reg <= result_valid_next;
            fault_reg <= fault_next;
        end
    end

    // read data, held from one read setup to the next
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

    //------------------------------------------------------------
    // outputs
    //------------------------------------------------------------
    // polarity picks the level that signals a fault
    assign overcurrent_fault_output = ovc_polarity ? fault_reg : !fault_reg;
    assign irq = |(irq_status_reg & irq_mask_reg);
    assign prdata = prdata_reg;
    assign result_valid = result_valid_reg;
    assign result_data = result_reg;
endmodule

// [tb/sac_props.sv]
`timescale 1ns/100ps
module sac_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // converter and comparator
    input wire logic shunt_converter_a_enable,
    input wire logic raw_valid,
    input wire logic [3:0] high_threshold_flag,
    input wire logic [3:0] low_threshold_flag,
    input wire logic result_valid,
    input wire logic fast_filter_enable,
    input wire logic [4:0] overcurrent_sample_count,
    input wire logic overcurrent_fault_output
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic cfg_wr, hit, act, idle, en_reg, pol_reg, low_rd;
    logic [4:0] cnt_reg;
    logic [2:0] act_reg, idle_reg;
    // shadow of the comparator config, tracked from lane 1 writes
    assign cfg_wr = psel && penable && pwrite && pstrb[1] && paddr == 12'h21c;
    assign hit = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0 && paddr[9:2] >= 8'h84 && paddr[9:2] <= 8'h8b;
    assign act = (|high_threshold_flag || |low_threshold_flag) && en_reg && shunt_converter_a_enable;
    assign idle = high_threshold_flag == 4'h0 && low_threshold_flag == 4'h0;
    assign low_rd = psel && penable && !pwrite && (paddr == 12'h214 || paddr == 12'h21c);
    // flags pass a synchroniser, so only steady stretches of seven cycles are judged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {en_reg, pol_reg, cnt_reg, act_reg, idle_reg} <= '0;
        end else begin
            if (cfg_wr) begin
                {en_reg, pol_reg, cnt_reg} <= {pwdata[15:14], pwdata[12:8]};
            end
            act_reg <= (cfg_wr || !act) ? 3'h0 : act_reg + 3'(act_reg != 3'h7);
            idle_reg <= (cfg_wr || !idle) ? 3'h0 : idle_reg + 3'(idle_reg != 3'h7);
        end
    end
    a_filter_gate: assert property (fast_filter_enable == (en_reg && shunt_converter_a_enable))
        else $error("fast filter enable does not follow enable and converter");
    a_count_field: assert property (overcurrent_sample_count == cnt_reg)
        else $error("sample count differs from written config");
    a_fault_active: assert property (act_reg == 3'h7 |-> overcurrent_fault_output == pol_reg)
        else $error("fault output level wrong during fault");
    a_fault_idle: assert property (idle_reg == 3'h7 |-> overcurrent_fault_output == !pol_reg)
        else $error("fault output level wrong when idle");
    a_bad_addr: assert property (psel && penable && !hit |-> pslverr)
        else $error("no error on unmapped access");
    a_good_addr: assert property (psel && penable && hit |-> !pslverr)
        else $error("error on mapped access");
    a_result_latency: assert property (raw_valid && shunt_converter_a_enable |-> ##4 result_valid)
        else $error("corrected result late or missing");
    a_result_cause: assert property (result_valid |-> $past(raw_valid, 4) && !$past(result_valid))
        else $error("result without request");
    a_low_zero: assert property (low_rd |-> prdata[7:0] == 8'h00)
        else $error("reserved low byte not zero");
endmodule
bind sac_top sac_props chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pslverr, .shunt_converter_a_enable, .raw_valid, .high_threshold_flag, .low_threshold_flag, .result_valid,
    .fast_filter_enable, .overcurrent_sample_count, .overcurrent_fault_output);

// [tb/testbench.sv]
`timescale 1ns/100ps
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready, pslverr, result_valid, fast_filter_enable, overcurrent_fault_output, irq;
    logic shunt_converter_a_enable = 1'b0, raw_valid = 1'b0;
    logic [23:0] raw_result = 24'h0;
    logic [23:0] result_data;
    logic [3:0] high_threshold_flag = 4'h0, low_threshold_flag = 4'h0;
    logic [4:0] overcurrent_sample_count;
    int failures = 0, checks_done = 0;
    logic [31:0] rng = 32'h00016136;
    sac_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .shunt_converter_a_enable, .raw_valid, .raw_result, .high_threshold_flag, .low_threshold_flag,
        .result_valid, .result_data, .fast_filter_enable, .overcurrent_sample_count, .overcurrent_fault_output, .irq);
    // 250 mhz clock
    always #2 pclk = ~pclk;
    // --------------------------------
    // helpers
    // --------------------------------
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    // expected output: raw code offset, then gain, clamped; msb flags saturation
    function automatic logic [24:0] corr(logic [23:0] raw, logic [23:0] off, logic [15:0] g);
        longint s;
        s = longint'($signed(raw)) + longint'($signed(off));
        s = (s * (65536 + longint'($signed(g)))) >>> 16;
        if (s > 8388607) return {1'b1, 24'h7fffff};
        if (s < -8388608) return {1'b1, 24'h800000};
        return {1'b0, s[23:0]};
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // one apb transfer; the wait is bounded so a stuck slave cannot hang the run
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= w ? 4'hf : 4'h0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        check("pready", 32'h1, {31'h0, pready});
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb({2'h0, i, 2'h0}, 1'b1, d, r, e);
    endtask
    task automatic rd(input logic [7:0] i, input logic [31:0] exp, input string what);
        logic [31:0] r;
        logic e;
        apb({2'h0, i, 2'h0}, 1'b0, 32'h0, r, e);
        check(what, exp, r);
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // watchdog, far beyond the several hundred cycles the sequence needs
    initial begin
        #100000;
        failures++;
        tally_and_finish();
    end
    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        logic [31:0] d, r;
        logic [23:0] off, raw;
        logic [15:0] g;
        logic [24:0] e;
        logic er;
        int n;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) rd(8'(8'h84 + i), 32'h0, "reset value");
        for (int k = 0; k < 8; k++) begin
            d = (k == 0) ? 32'hffffffff : rnd();
            for (int i = 0; i < 4; i++) wr(8'(8'h84 + i), d);
            rd(8'h84, {16'h0, d[15:0]}, "offset high");
            rd(8'h85, {16'h0, d[15:8], 8'h00}, "offset low");
            rd(8'h86, {16'h0, d[15:0]}, "gain trim");
            rd(8'h87, {16'h0, d[15:8], 8'h00}, "comparator config");
            check("sample count", {27'h0, d[12:8]}, {27'h0, overcurrent_sample_count});
        end
        apb(12'h240, 1'b0, 32'h0, r, er);
        check("unmapped error", 32'h1, {31'h0, er});
        check("unmapped read", 32'h0, r);
        apb(12'h211, 1'b1, 32'hffff, r, er);
        check("misaligned error", 32'h1, {31'h0, er});
        wr(8'h87, 32'h0);
        shunt_converter_a_enable <= 1'b1;
        for (int k = 0; k < 10; k++) begin
            d = rnd();
            off = d[23:0];
            d = rnd();
            g = d[15:0];
            d = rnd();
            raw = d[23:0];
            // corners: both clamps and unity gain
            if (k == 0) {raw, off, g} = {24'h7fffff, 24'h7fffff, 16'h7fff};
            if (k == 1) {raw, off, g} = {24'h800000, 24'h800000, 16'h8001};
            if (k == 2) g = 16'h0000;
            wr(8'h84, {16'h0, off[23:8]});
            wr(8'h85, {16'h0, off[7:0], 8'h00});
            wr(8'h86, {16'h0, g});
            wr(8'h89, {31'h0, k[0]});
            wr(8'h88, 32'h7);
            e = corr(raw, off, g);
            @(posedge pclk);
            raw_valid <= 1'b1;
            raw_result <= raw;
            @(posedge pclk);
            raw_valid <= 1'b0;
            n = 0;
            // look between edges so the one-cycle pulse is seen while it stands
            while (result_valid !== 1'b1 && n < 20) begin
                @(negedge pclk);
                n++;
            end
            check("result valid", 32'h1, {31'h0, result_valid});
            check("corrected result", {8'h0, e[23:0]}, {8'h0, result_data});
            repeat (2) @(posedge pclk);
            check("irq masked level", {31'h0, k[0]}, {31'h0, irq});
            rd(8'h88, {29'h0, e[24], 2'h1}, "irq status");
            rd(8'h8a, {8'h0, e[23:0]}, "result register");
            wr(8'h88, 32'h7);
            repeat (2) @(posedge pclk);
            check("irq cleared", 32'h0, {31'h0, irq});
        end
        for (int p = 0; p < 2; p++) begin
            wr(8'h88, 32'h7);
            wr(8'h89, 32'h2);
            wr(8'h87, {16'h0, 1'b1, p[0], 14'h0});
            @(posedge pclk);
            check("filter enable", 32'h1, {31'h0, fast_filter_enable});
            d = rnd();
            high_threshold_flag <= d[3:0];
            low_threshold_flag <= d[7:4] | {3'h0, d[3:0] == 4'h0};
            repeat (8) @(posedge pclk);
            check("fault active", {31'h0, p[0]}, {31'h0, overcurrent_fault_output});
            check("fault irq", 32'h1, {31'h0, irq});
            high_threshold_flag <= 4'h0;
            low_threshold_flag <= 4'h0;
            repeat (8) @(posedge pclk);
            check("fault idle", {31'h0, !p[0]}, {31'h0, overcurrent_fault_output});
        end
        shunt_converter_a_enable <= 1'b0;
        repeat (2) @(posedge pclk);
        check("filter gated", 32'h0, {31'h0, fast_filter_enable});
        // second reset in mid-run: trims and comparator config return to zero
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check("fault level in reset", 32'h1, {31'h0, overcurrent_fault_output});
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) rd(8'(8'h84 + i), 32'h0, "value after reset");
        tally_and_finish();
    end
endmodule
